// File: hw/hms_pkg.sv
// Purpose: shared constants and types of the homing method sequencer
// Assumes: one 10 MHz clock, switch and index inputs already synchronous
// Notes: control word values and method codes are fixed by the drive profile
package hms_pkg;

    localparam int CLOCK_HZ = 10_000_000;

    // control word values that arm a homing run
    localparam logic [15:0] HMS_CTRL_ENABLED = 16'h000f;
    localparam logic [15:0] HMS_CTRL_HOMING = 16'h001f;

    // supported method codes
    localparam logic [7:0] HMS_M14 = 8'h0e;
    localparam logic [7:0] HMS_M17 = 8'h11;
    localparam logic [7:0] HMS_M18 = 8'h12;
    localparam logic [7:0] HMS_M19 = 8'h13;
    localparam logic [7:0] HMS_M20 = 8'h14;
    localparam logic [7:0] HMS_M21 = 8'h15;
    localparam logic [7:0] HMS_M22 = 8'h16;
    localparam logic [7:0] HMS_M23 = 8'h17;
    localparam logic [7:0] HMS_M24 = 8'h18;
    localparam logic [7:0] HMS_M25 = 8'h19;

    // switch vector layout
    localparam int HMS_SW_N = 3;
    localparam int HMS_SW_HOME = 0;
    localparam int HMS_SW_PLIM = 1;
    localparam int HMS_SW_NLIM = 2;

    // reset values
    localparam logic [1:0] HMS_PHASE_RST = 2'h0;
    localparam logic [7:0] HMS_METHOD_RST = 8'h00;

    typedef enum logic [1:0] {
        HMS_IDLE = 2'b00,
        HMS_MOVE = 2'b01,
        HMS_LATCH = 2'b10
    } hms_state_t;

    // one decision of the sequencer
    typedef struct packed {
        logic take;
        logic fwd;
        logic fast;
        logic [1:0] phase;
        logic finish;
        logic use_index;
    } hms_step_t;

endpackage

// File: hw/hms_edge_detect.sv
// Purpose: sample switch inputs each cycle and flag their edges
// Assumes: inputs are synchronous to clock, high means active
// Notes: edges show in the same cycle as the sample that reveals them
`timescale 1ns/100ps
module hms_edge_detect
    import hms_pkg::*;
#(
    parameter int N = HMS_SW_N
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [N-1:0] sw_in,
    output logic [N-1:0] level,
    output logic [N-1:0] rise,
    output logic [N-1:0] fall
);

    // refused at elaboration: an empty switch vector has no edges to report
    if (N < 1) begin : g_check_n
        $error("hms_edge_detect needs at least one input");
    end

    typedef struct packed {
        logic [N-1:0] cur;
        logic [N-1:0] prev;
    } hms_edge_regs_t;

    hms_edge_regs_t edge_reg;
    hms_edge_regs_t edge_next;

    always_comb begin
        edge_next = edge_reg;
        edge_next.cur = sw_in;
        edge_next.prev = edge_reg.cur;
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            edge_reg <= '0;
        end else begin
            edge_reg <= edge_next;
        end
    end

    assign level = edge_reg.cur;
    assign rise = edge_reg.cur & ~edge_reg.prev;
    assign fall = ~edge_reg.cur & edge_reg.prev;

endmodule

// File: hw/hms_home_latch.sv
// Purpose: capture the home position at once or at the next index pulse
// Assumes: arm is a one-cycle pulse, cancel aborts a pending capture
// Notes: an index in the arming cycle itself is not taken
`timescale 1ns/100ps
module hms_home_latch #(
    parameter int POS_W = 32
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic arm,
    input wire logic use_index,
    input wire logic cancel,
    input wire logic index_pulse,
    input wire logic [POS_W-1:0] position,
    output logic done,
    output logic [POS_W-1:0] home_pos
);

    // refused at elaboration rather than at run time
    if (POS_W < 2) begin : g_check_pos_w
        $error("hms_home_latch needs POS_W of at least 2");
    end

    typedef struct packed {
        logic wait_index;
        logic done;
        logic [POS_W-1:0] pos;
    } hms_latch_regs_t;

    hms_latch_regs_t lat_reg;
    hms_latch_regs_t lat_next;

    always_comb begin
        lat_next = lat_reg;
        lat_next.done = 1'b0;
        if (cancel) begin
            lat_next.wait_index = 1'b0;
        end else if (arm && !use_index) begin
            lat_next.pos = position;
            lat_next.done = 1'b1;
        end else if (arm) begin
            lat_next.wait_index = 1'b1;
        end else if (lat_reg.wait_index && index_pulse) begin
            // first index after the arming edge wins
            lat_next.pos = position;
            lat_next.done = 1'b1;
            lat_next.wait_index = 1'b0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            lat_reg <= '0;
        end else begin
            lat_reg <= lat_next;
        end
    end

    assign done = lat_reg.done;
    assign home_pos = lat_reg.pos;

endmodule

// File: hw/hms_sequencer.sv
// Purpose: homing method sequencer for methods 14 and 17 to 25
// Assumes: one 10 MHz clock; switches and index synchronous and active high
// Notes: direction and speed are levels for the velocity loop, not a profile
`timescale 1ns/100ps
module hms_sequencer
    import hms_pkg::*;
#(
    parameter int POS_W = 32
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [15:0] control_word,
    input wire logic [7:0] homing_method,
    input wire logic home_switch,
    input wire logic pos_limit,
    input wire logic neg_limit,
    input wire logic index_pulse,
    input wire logic [POS_W-1:0] actual_position,
    output logic motion_enable,
    output logic move_positive,
    output logic speed_high,
    output logic homing_busy,
    output logic homing_done,
    output logic homing_fault,
    output logic [POS_W-1:0] home_position
);

    // refused at elaboration: the capture path needs at least 2 bits; this module also caps POS_W at 64
    if (POS_W < 2 || POS_W > 64) begin : g_check_pos_w
        $error("hms_sequencer needs POS_W between 2 and 64");
    end

    typedef struct packed {
        hms_state_t st;
        logic [1:0] phase;
        logic [7:0] method;
        logic [15:0] ctrl_prev;
        logic run;
        logic fwd;
        logic fast;
        logic busy;
        logic done;
        logic fault;
        logic arm;
        logic use_index;
    } hms_regs_t;

    hms_regs_t seq_reg;
    hms_regs_t seq_next;

    logic [HMS_SW_N-1:0] sw_level;
    logic [HMS_SW_N-1:0] sw_rise;
    logic [HMS_SW_N-1:0] sw_fall;
    logic latch_done;
    logic abort;
    logic start;
    hms_step_t first_step;
    hms_step_t move_step;

    hms_edge_detect #(
        .N(HMS_SW_N)
    ) u_edges (
        .clock(clock),
        .reset_n(reset_n),
        .sw_in({neg_limit, pos_limit, home_switch}),
        .level(sw_level),
        .rise(sw_rise),
        .fall(sw_fall)
    );

    hms_home_latch #(
        .POS_W(POS_W)
    ) u_latch (
        .clock(clock),
        .reset_n(reset_n),
        .arm(seq_reg.arm),
        .use_index(seq_reg.use_index),
        .cancel(abort),
        .index_pulse(index_pulse),
        .position(actual_position),
        .done(latch_done),
        .home_pos(home_position)
    );

    function automatic hms_step_t go(input logic fwd, input logic fast, input logic [1:0] ph);
        hms_step_t s;
        s = '0;
        s.take = 1'b1;
        s.fwd = fwd;
        s.fast = fast;
        s.phase = ph;
        return s;
    endfunction

    function automatic hms_step_t fin(input logic use_index);
        hms_step_t s;
        s = '0;
        s.take = 1'b1;
        s.finish = 1'b1;
        s.use_index = use_index;
        return s;
    endfunction

    function automatic logic supported(input logic [7:0] m);
        return m == HMS_M14 || (m >= HMS_M17 && m <= HMS_M25);
    endfunction

    // first motion from the switch levels at start
    function automatic hms_step_t start_step(input logic [7:0] m, input logic home,
                                             input logic plim, input logic nlim);
        hms_step_t s;
        s = '0;
        case (m)
            HMS_M14: s = home ? go(1'b0, 1'b0, 2'h2) : go(1'b0, 1'b1, 2'h0);
            HMS_M17: s = nlim ? go(1'b1, 1'b0, 2'h1) : go(1'b0, 1'b1, 2'h0);
            HMS_M18: s = plim ? go(1'b0, 1'b0, 2'h1) : go(1'b1, 1'b1, 2'h0);
            HMS_M19: s = home ? go(1'b0, 1'b0, 2'h1) : go(1'b1, 1'b1, 2'h0);
            HMS_M20: s = home ? go(1'b0, 1'b0, 2'h0) : go(1'b1, 1'b0, 2'h1);
            HMS_M21: s = home ? go(1'b1, 1'b0, 2'h1) : go(1'b0, 1'b1, 2'h0);
            HMS_M22: s = home ? go(1'b1, 1'b0, 2'h0) : go(1'b0, 1'b0, 2'h1);
            HMS_M23: s = home ? go(1'b0, 1'b0, 2'h2) : go(1'b1, 1'b1, 2'h0);
            HMS_M24: s = home ? go(1'b0, 1'b0, 2'h2) : go(1'b1, 1'b1, 2'h0);
            HMS_M25: s = home ? go(1'b1, 1'b0, 2'h2) : go(1'b1, 1'b1, 2'h0);
            default: s = '0;
        endcase
        return s;
    endfunction

    // reaction to switch edges while moving; limit edges checked before home edges
    function automatic hms_step_t run_step(input logic [7:0] m, input logic [1:0] ph,
                                           input logic [HMS_SW_N-1:0] r,
                                           input logic [HMS_SW_N-1:0] f);
        hms_step_t s;
        logic hr;
        logic hf;
        logic pr;
        logic nr;
        logic pf;
        logic nf;
        s = '0;
        hr = r[HMS_SW_HOME];
        hf = f[HMS_SW_HOME];
        pr = r[HMS_SW_PLIM];
        nr = r[HMS_SW_NLIM];
        pf = f[HMS_SW_PLIM];
        nf = f[HMS_SW_NLIM];
        case (m)
            HMS_M14: begin
                case (ph)
                    2'h0: begin
                        if (nr) begin
                            s = go(1'b1, 1'b1, 2'h1);
                        end else if (hr) begin
                            s = go(1'b0, 1'b0, 2'h2);
                        end
                    end
                    2'h1: if (hr) s = go(1'b0, 1'b0, 2'h2);
                    2'h2: if (hf) s = fin(1'b1);
                    default: s = '0;
                endcase
            end
            HMS_M17: begin
                case (ph)
                    2'h0: if (nr) s = go(1'b1, 1'b0, 2'h1);
                    2'h1: if (nf) s = fin(1'b0);
                    default: s = '0;
                endcase
            end
            HMS_M18: begin
                case (ph)
                    2'h0: if (pr) s = go(1'b0, 1'b0, 2'h1);
                    2'h1: if (pf) s = fin(1'b0);
                    default: s = '0;
                endcase
            end
            HMS_M19: begin
                case (ph)
                    2'h0: if (hr) s = go(1'b0, 1'b0, 2'h1);
                    2'h1: if (hf) s = fin(1'b0);
                    default: s = '0;
                endcase
            end
            HMS_M20: begin
                case (ph)
                    2'h0: if (hf) s = go(1'b1, 1'b0, 2'h1);
                    2'h1: if (hr) s = fin(1'b0);
                    default: s = '0;
                endcase
            end
            HMS_M21: begin
                case (ph)
                    2'h0: if (hr) s = go(1'b1, 1'b0, 2'h1);
                    2'h1: if (hf) s = fin(1'b0);
                    default: s = '0;
                endcase
            end
            HMS_M22: begin
                case (ph)
                    2'h0: if (hf) s = go(1'b0, 1'b0, 2'h1);
                    2'h1: if (hr) s = fin(1'b0);
                    default: s = '0;
                endcase
            end
            HMS_M23: begin
                case (ph)
                    2'h0: begin
                        if (pr) begin
                            s = go(1'b0, 1'b1, 2'h1);
                        end else if (hr) begin
                            s = go(1'b0, 1'b0, 2'h2);
                        end
                    end
                    2'h1: if (hr) s = go(1'b0, 1'b0, 2'h2);
                    2'h2: if (hf) s = fin(1'b0);
                    default: s = '0;
                endcase
            end
            HMS_M24: begin
                case (ph)
                    2'h0: begin
                        if (pr) begin
                            s = go(1'b0, 1'b1, 2'h1);
                        end else if (hr) begin
                            s = go(1'b0, 1'b0, 2'h2);
                        end
                    end
                    2'h1: if (hr) s = go(1'b0, 1'b0, 2'h2);
                    2'h2: if (hf) s = go(1'b1, 1'b0, 2'h3);
                    2'h3: if (hr) s = fin(1'b0);
                    default: s = '0;
                endcase
            end
            HMS_M25: begin
                case (ph)
                    2'h0: begin
                        if (pr) begin
                            s = go(1'b0, 1'b1, 2'h1);
                        end else if (hr) begin
                            s = go(1'b1, 1'b0, 2'h2);
                        end
                    end
                    2'h1: if (hr) s = go(1'b1, 1'b0, 2'h2);
                    2'h2: if (hf) s = go(1'b0, 1'b0, 2'h3);
                    2'h3: if (hr) s = fin(1'b0);
                    default: s = '0;
                endcase
            end
            default: s = '0;
        endcase
        return s;
    endfunction

    // start only on the enabled-to-homing step of the control word
    assign start = seq_reg.ctrl_prev == HMS_CTRL_ENABLED && control_word == HMS_CTRL_HOMING;
    // dropping the homing value stops the run at once
    assign abort = seq_reg.busy && control_word != HMS_CTRL_HOMING;
    assign first_step = start_step(homing_method, sw_level[HMS_SW_HOME], sw_level[HMS_SW_PLIM],
                                   sw_level[HMS_SW_NLIM]);
    assign move_step = run_step(seq_reg.method, seq_reg.phase, sw_rise, sw_fall);

    always_comb begin
        seq_next = seq_reg;
        seq_next.ctrl_prev = control_word;
        seq_next.arm = 1'b0;
        case (seq_reg.st)
            HMS_IDLE: begin
                if (start) begin
                    seq_next.done = 1'b0;
                    if (supported(homing_method)) begin
                        seq_next.method = homing_method;
                        seq_next.st = HMS_MOVE;
                        seq_next.phase = first_step.phase;
                        seq_next.fwd = first_step.fwd;
                        seq_next.fast = first_step.fast;
                        seq_next.run = 1'b1;
                        seq_next.busy = 1'b1;
                        seq_next.fault = 1'b0;
                    end else begin
                        seq_next.fault = 1'b1;
                    end
                end
            end
            HMS_MOVE: begin
                if (abort) begin
                    seq_next.st = HMS_IDLE;
                    seq_next.run = 1'b0;
                    seq_next.busy = 1'b0;
                end else if (move_step.take && move_step.finish) begin
                    // position capture keeps moving only while an index is awaited
                    seq_next.st = HMS_LATCH;
                    seq_next.arm = 1'b1;
                    seq_next.use_index = move_step.use_index;
                    seq_next.run = move_step.use_index;
                end else if (move_step.take) begin
                    seq_next.phase = move_step.phase;
                    seq_next.fwd = move_step.fwd;
                    seq_next.fast = move_step.fast;
                end
            end
            HMS_LATCH: begin
                if (abort) begin
                    seq_next.st = HMS_IDLE;
                    seq_next.run = 1'b0;
                    seq_next.busy = 1'b0;
                end else if (latch_done) begin
                    seq_next.st = HMS_IDLE;
                    seq_next.run = 1'b0;
                    seq_next.busy = 1'b0;
                    seq_next.done = 1'b1;
                end
            end
            default: begin
                seq_next.st = HMS_IDLE;
                seq_next.run = 1'b0;
                seq_next.busy = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            seq_reg <= '0;
            seq_reg.st <= HMS_IDLE;
            seq_reg.phase <= HMS_PHASE_RST;
            seq_reg.method <= HMS_METHOD_RST;
        end else begin
            seq_reg <= seq_next;
        end
    end

    assign motion_enable = seq_reg.run;
    assign move_positive = seq_reg.fwd;
    assign speed_high = seq_reg.fast;
    assign homing_busy = seq_reg.busy;
    assign homing_done = seq_reg.done;
    assign homing_fault = seq_reg.fault;

endmodule

// File: bench/hms_sequencer_props.sv
// Purpose: port-level checks of the homing sequencer
// Assumes: one clock, reset_n active low, switches steady around a start
// Notes: switch edges reach the outputs one edge after they are sampled
`timescale 1ns/100ps
module hms_sequencer_props
    import hms_pkg::*;
#(
    parameter int POS_W = 32
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic [15:0] control_word,
    input wire logic [7:0] homing_method,
    input wire logic home_switch,
    input wire logic pos_limit,
    input wire logic neg_limit,
    input wire logic index_pulse,
    input wire logic [POS_W-1:0] actual_position,
    input wire logic motion_enable,
    input wire logic move_positive,
    input wire logic speed_high,
    input wire logic homing_busy,
    input wire logic homing_done,
    input wire logic homing_fault,
    input wire logic [POS_W-1:0] home_position
);
    logic [15:0] cw_prev_reg;
    logic start_w;
    logic sup_w;
    logic [2:0] sw_w;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            cw_prev_reg <= 16'h0000;
        end else begin
            cw_prev_reg <= control_word;
        end
    end
    assign start_w = control_word == HMS_CTRL_HOMING && cw_prev_reg == HMS_CTRL_ENABLED && !homing_busy;
    assign sup_w = homing_method inside {HMS_M14, [HMS_M17:HMS_M25]};
    assign sw_w = {home_switch, pos_limit, neg_limit};
    default clocking @(posedge clock); endclocking
    default disable iff (!reset_n);
    start_run_a: assert property (start_w && sup_w |=> homing_busy && motion_enable && !homing_fault)
        else $error("supported start did not begin a run");
    bad_method_a: assert property (start_w && !sup_w |=> homing_fault && !homing_busy && !motion_enable)
        else $error("unsupported method not refused");
    no_trigger_a: assert property (!homing_busy && !start_w |=> !homing_busy)
        else $error("run began without trigger");
    abort_run_a: assert property (homing_busy && control_word != HMS_CTRL_HOMING
        |=> !homing_busy && !homing_done) else $error("run not aborted");
    m14_dir_a: assert property (start_w && homing_method == HMS_M14 && !home_switch && !$past(home_switch)
        |=> !move_positive && speed_high) else $error("method 14 start wrong");
    m17_dir_a: assert property (start_w && homing_method == HMS_M17 && neg_limit && $past(neg_limit)
        |=> move_positive && !speed_high) else $error("method 17 start wrong");
    m18_dir_a: assert property (start_w && homing_method == HMS_M18 && !pos_limit && !$past(pos_limit)
        |=> move_positive && speed_high) else $error("method 18 start wrong");
    m22_dir_a: assert property (start_w && homing_method == HMS_M22 && home_switch && $past(home_switch)
        |=> move_positive && !speed_high) else $error("method 22 start wrong");
    // a turn seen now was caused by a switch change between the samples two and three edges back
    dir_cause_a: assert property (homing_busy && $past(homing_busy) && $changed(move_positive)
        |-> $past(sw_w, 2) != $past(sw_w, 3)) else $error("turn without edge");
    stop_done_a: assert property ($fell(motion_enable) && homing_busy |-> ##[1:3] homing_done)
        else $error("stop without completion");
    done_fall_a: assert property ($rose(homing_done) |-> $fell(homing_busy) && !motion_enable)
        else $error("done without end of run");
    pos_hold_a: assert property (!homing_busy |=> $stable(home_position))
        else $error("home position moved while idle");
    cover property (start_w && sup_w);
    cover property ($rose(homing_done));
    cover property ($rose(homing_fault));
    cover property (homing_busy && control_word != HMS_CTRL_HOMING);
endmodule
bind hms_sequencer hms_sequencer_props #(.POS_W(POS_W)) u_props (.clock(clock), .reset_n(reset_n),
    .control_word(control_word), .homing_method(homing_method), .home_switch(home_switch),
    .pos_limit(pos_limit), .neg_limit(neg_limit), .index_pulse(index_pulse),
    .actual_position(actual_position), .motion_enable(motion_enable), .move_positive(move_positive),
    .speed_high(speed_high), .homing_busy(homing_busy), .homing_done(homing_done),
    .homing_fault(homing_fault), .home_position(home_position));

// File: bench/hms_motor_model.sv
// Purpose: axis with home switch, limits and index on a position line
// Assumes: high speed is two counts a cycle, low speed one
// Notes: index every 64 counts; load only while the sequencer is idle
`timescale 1ns/100ps
module hms_motor_model #(
    parameter int POS_W = 32,
    parameter int HOME_LO = 100,
    parameter int HOME_HI = 140,
    parameter int NEG_END = -200,
    parameter int POS_END = 300
) (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic load,
    input wire logic signed [31:0] load_pos,
    input wire logic motion_enable,
    input wire logic move_positive,
    input wire logic speed_high,
    output logic home_switch,
    output logic pos_limit,
    output logic neg_limit,
    output logic index_pulse,
    output logic [POS_W-1:0] actual_position
);
    int pos;
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            pos <= 0;
        end else if (load) begin
            pos <= int'(load_pos);
        end else if (motion_enable) begin
            pos <= pos + (move_positive ? 1 : -1) * (speed_high ? 2 : 1);
        end
    end
    // switches follow position only, so overshoot past an edge is real
    assign home_switch = pos >= HOME_LO && pos <= HOME_HI;
    assign pos_limit = pos >= POS_END;
    assign neg_limit = pos <= NEG_END;
    assign index_pulse = (pos & 63) == 0;
    assign actual_position = POS_W'(pos);
endmodule

// File: bench/hms_sequencer_tb.sv
// Purpose: self-checking bench of the homing sequencer
// Assumes: home band 100..140, limits at -200 and 300, index every 64
// Notes: home position judged within 4 counts of the expected edge
`timescale 1ns/100ps
module hms_sequencer_tb;
    import hms_pkg::*;
    logic clock;
    logic reset_n;
    logic [15:0] control_word;
    logic [7:0] homing_method;
    logic home_switch, pos_limit, neg_limit, index_pulse;
    logic [31:0] actual_position, home_position;
    logic motion_enable, move_positive, speed_high, homing_busy, homing_done, homing_fault;
    logic load;
    logic signed [31:0] load_pos;
    int bad_count = 0;
    int checked = 0;

    hms_sequencer #(.POS_W(32)) u_dut (.clock(clock), .reset_n(reset_n), .control_word(control_word),
        .homing_method(homing_method), .home_switch(home_switch), .pos_limit(pos_limit),
        .neg_limit(neg_limit), .index_pulse(index_pulse), .actual_position(actual_position),
        .motion_enable(motion_enable), .move_positive(move_positive), .speed_high(speed_high),
        .homing_busy(homing_busy), .homing_done(homing_done), .homing_fault(homing_fault),
        .home_position(home_position));
    hms_motor_model u_motor (.clock(clock), .reset_n(reset_n), .load(load), .load_pos(load_pos),
        .motion_enable(motion_enable), .move_positive(move_positive), .speed_high(speed_high),
        .home_switch(home_switch), .pos_limit(pos_limit), .neg_limit(neg_limit),
        .index_pulse(index_pulse), .actual_position(actual_position));

    initial begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    task automatic end_sim;
        if (bad_count == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic tick;
        @(posedge clock);
        #1;
    endtask

    task automatic chk_bit(input logic [3:0] got, input logic [3:0] exp, input string msg);
        checked++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    task automatic chk_pos(input logic [31:0] got, input int exp);
        int d;
        d = int'($signed(got)) - exp;
        checked++;
        if ((^got === 1'bx) || d > 4 || d < -4) begin
            bad_count++;
            $display("CHECK FAILED %0t home position %0d far from %0d", $time, $signed(got), exp);
        end
    endtask

    // place the axis and let the switch history settle before a start
    task automatic arm(input logic [7:0] m, input int start);
        control_word = HMS_CTRL_ENABLED;
        homing_method = m;
        load = 1'b1;
        load_pos = start;
        tick();
        load = 1'b0;
        repeat (3) tick();
    endtask

    task automatic run_home(input logic [7:0] m, input int start, input int exp);
        int n;
        arm(m, start);
        control_word = HMS_CTRL_HOMING;
        // let the start edge pass so the done flag of the last run is cleared first
        tick();
        for (n = 0; n < 3000 && homing_done !== 1'b1; n++) tick();
        chk_bit({homing_done, homing_busy, motion_enable, homing_fault}, 4'b1000, "run did not end cleanly");
        chk_pos(home_position, exp);
    endtask

    task automatic t_trigger;
        arm(HMS_M19, 0);
        control_word = 16'h0000;
        tick();
        control_word = HMS_CTRL_HOMING;
        repeat (3) tick();
        chk_bit({3'b000, homing_busy}, 4'b0000, "start without enabled word");
    endtask

    task automatic t_fault;
        arm(8'h0f, 0);
        control_word = HMS_CTRL_HOMING;
        repeat (2) tick();
        chk_bit({homing_fault, homing_busy, motion_enable, 1'b0}, 4'b1000, "bad method not refused");
    endtask

    // abort in mid-run: the run must drop without a completion
    task automatic t_abort;
        arm(HMS_M19, 0);
        control_word = HMS_CTRL_HOMING;
        repeat (10) tick();
        chk_bit({homing_fault, motion_enable, move_positive, speed_high}, 4'b0111, "m19 first leg");
        control_word = HMS_CTRL_ENABLED;
        repeat (2) tick();
        chk_bit({homing_busy, homing_done, motion_enable, 1'b0}, 4'b0000, "abort failed");
    endtask

    task automatic t_m14;
        run_home(HMS_M14, 200, 64);
        run_home(HMS_M14, 120, 64);
        run_home(HMS_M14, 50, 64);
    endtask

    task automatic t_limits;
        run_home(HMS_M17, 0, -199);
        run_home(HMS_M17, -210, -199);
        run_home(HMS_M18, 0, 299);
        run_home(HMS_M18, 310, 299);
    endtask

    task automatic t_home_sw;
        run_home(HMS_M19, 0, 99);
        run_home(HMS_M19, 120, 99);
        run_home(HMS_M20, 0, 100);
        run_home(HMS_M20, 120, 100);
        run_home(HMS_M21, 200, 141);
        run_home(HMS_M21, 120, 141);
        run_home(HMS_M22, 200, 140);
        run_home(HMS_M22, 120, 140);
    endtask

    task automatic t_m23_25;
        run_home(HMS_M23, 0, 99);
        run_home(HMS_M23, 120, 99);
        run_home(HMS_M23, 200, 99);
        run_home(HMS_M24, 0, 100);
        run_home(HMS_M24, 120, 100);
        run_home(HMS_M24, 200, 100);
        run_home(HMS_M25, 0, 140);
        run_home(HMS_M25, 120, 140);
        run_home(HMS_M25, 200, 140);
    endtask

    initial begin
        reset_n = 1'b0;
        control_word = 16'h0000;
        homing_method = 8'h00;
        load = 1'b0;
        load_pos = 32'sh0;
        repeat (16) @(posedge clock);
        #1;
        reset_n = 1'b1;
        tick();
        t_trigger();
        t_fault();
        t_abort();
        t_m14();
        t_limits();
        t_home_sw();
        t_m23_25();
        end_sim();
    end

    // 24 homing runs of at most a few hundred cycles each, plus three short tests, fit well inside this
    initial begin
        repeat (40000) @(posedge clock);
        bad_count++;
        $display("CHECK FAILED %0t watchdog expired", $time);
        end_sim();
    end
endmodule
